/* File: hdl/torque_reference_select_limit.sv */
// torque-mode reference select, offset, lag filter and speed limit
`timescale 1ns/1ns
`default_nettype none
module torque_reference_select_limit #(
    parameter int IN_PINS = 8,
    parameter int MOTOR_RATED_RPM = 3000,
    parameter int MOTOR_MAX_RPM = 6000,
    parameter int HOLD_CYC = trsl_pkg::KEY_HOLD_CYC
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire trsl_pkg::trsl_bus_t busReq,
    output logic [15:0] rdData,
    input wire logic servoOn,
    input wire trsl_pkg::trsl_keys_t keys,
    input wire logic [IN_PINS-1:0] digIn,
    input wire logic signed [15:0] torqueRefAdc,
    input wire logic signed [15:0] speedRefAdc,
    input wire logic signed [15:0] motorSpeed,
    input wire logic signed [11:0] nvOffsetIn,
    output logic signed [11:0] nvOffsetOut,
    output logic nvWriteStb,
    output logic offsetShow,
    output logic signed [11:0] offsetDisplay,
    output logic signed [15:0] torqueCmd,
    output logic [15:0] speedLimit,
    output logic limitActive
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic signed [15:0] clampS(input logic signed [15:0] v,
            input logic signed [15:0] lo, input logic signed [15:0] hi);
        if (v < lo) begin
            return lo;
        end
        if (v > hi) begin
            return hi;
        end
        return v;
    endfunction

    function automatic logic pickPin(input logic [15:0] pins, input logic [3:0] idx);
        return pins[idx];
    endfunction

    function automatic logic signed [31:0] absS(input logic signed [31:0] v);
        return (v < 0) ? -v : v;
    endfunction

    // ------------------------------------------------------------
    // parameter registers
    // ------------------------------------------------------------
    logic [15:0] ctrlReg;
    logic signed [15:0] filtTcReg;
    logic signed [15:0] spdLimReg;
    logic signed [15:0] gainReg;
    logic signed [15:0] tPreReg [4];
    logic signed [15:0] sCapReg [4];
    logic [15:0] allocAReg;
    logic [15:0] allocBReg;
    logic signed [11:0] offsetReg;
    logic autoRefused;
    logic loadPend;
    logic [31:0] holdCnt;
    logic signed [31:0] filtAcc;
    logic [15:0] tickCnt;
    logic filtTick;

    logic wrCtrl;
    logic autoReq;
    logic restoreReq;
    logic [1:0] widx;
    assign wrCtrl = busReq.wr && (busReq.addr == trsl_pkg::REG_CTRL);
    assign autoReq = wrCtrl && busReq.wdata[trsl_pkg::CTRL_AUTO_BIT];
    assign restoreReq = wrCtrl && busReq.wdata[trsl_pkg::CTRL_RESTORE_BIT];
    assign widx = busReq.addr[1:0];

    logic signed [15:0] wval;
    assign wval = busReq.wdata;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrlReg <= trsl_pkg::CTRL_DEF;
            filtTcReg <= trsl_pkg::FILT_DEF;
            spdLimReg <= trsl_pkg::SPDLIM_DEF;
            gainReg <= trsl_pkg::GAIN_DEF;
            allocAReg <= trsl_pkg::ALLOC_DEF;
            allocBReg <= trsl_pkg::ALLOC_DEF;
            for (int i = 0; i < 4; i++) begin
                tPreReg[i] <= trsl_pkg::TPRE_DEF;
                sCapReg[i] <= trsl_pkg::SCAP_DEF[i];
            end
        end else if (restoreReq) begin
            ctrlReg <= trsl_pkg::CTRL_DEF;
            filtTcReg <= trsl_pkg::FILT_DEF;
            spdLimReg <= trsl_pkg::SPDLIM_DEF;
            gainReg <= trsl_pkg::GAIN_DEF;
            allocAReg <= trsl_pkg::ALLOC_DEF;
            allocBReg <= trsl_pkg::ALLOC_DEF;
            for (int i = 0; i < 4; i++) begin
                tPreReg[i] <= trsl_pkg::TPRE_DEF;
                sCapReg[i] <= trsl_pkg::SCAP_DEF[i];
            end
        end else if (busReq.wr) begin
            case (busReq.addr)
                trsl_pkg::REG_CTRL: begin
                    // one-shot command bits are not stored
                    ctrlReg <= {7'h00, busReq.wdata[8], 2'h0, busReq.wdata[5:0]};
                end
                trsl_pkg::REG_FILT: filtTcReg <= clampS(wval, 16'sh0000, trsl_pkg::FILT_MAX);
                trsl_pkg::REG_SPDLIM: spdLimReg <= clampS(wval, 16'sh0000, trsl_pkg::SPDLIM_MAX);
                trsl_pkg::REG_GAIN: gainReg <= clampS(wval, trsl_pkg::GAIN_MIN, trsl_pkg::GAIN_MAX);
                trsl_pkg::REG_ALLOC_A: allocAReg <= busReq.wdata;
                trsl_pkg::REG_ALLOC_B: allocBReg <= busReq.wdata;
                default: begin
                    if (busReq.addr[3:2] == 2'h1) begin
                        tPreReg[widx] <= clampS(wval, -trsl_pkg::TPRE_LIM, trsl_pkg::TPRE_LIM);
                    end
                    if (busReq.addr[3:2] == 2'h2) begin
                        sCapReg[widx] <= clampS(wval, -trsl_pkg::SCAP_LIM, trsl_pkg::SCAP_LIM);
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // offset store: loaded from and written back to nonvolatile memory
    // ------------------------------------------------------------
    logic signed [15:0] adcClamp;
    logic signed [15:0] nvClamp;
    logic signed [15:0] stepVal;
    assign adcClamp = clampS(torqueRefAdc, -trsl_pkg::OFS_LIM, trsl_pkg::OFS_LIM);
    assign nvClamp = clampS(16'(nvOffsetIn), -trsl_pkg::OFS_LIM, trsl_pkg::OFS_LIM);
    assign stepVal = clampS(16'(offsetReg) + (keys.up ? 16'sh0001 : 16'shFFFF),
                            -trsl_pkg::OFS_LIM, trsl_pkg::OFS_LIM);

    // offset lives outside the parameter set
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            offsetReg <= 12'sh000;
            loadPend <= 1'b1;
            nvWriteStb <= 1'b0;
        end else begin
            nvWriteStb <= 1'b0;
            loadPend <= 1'b0;
            if (loadPend) begin
                offsetReg <= nvClamp[11:0];
            end else if (autoReq && !servoOn) begin
                offsetReg <= adcClamp[11:0];
                nvWriteStb <= 1'b1;
            end else if (offsetShow && (keys.up ^ keys.down)) begin
                offsetReg <= stepVal[11:0];
                nvWriteStb <= 1'b1;
            end
        end
    end
    assign nvOffsetOut = offsetReg;

    // refused while servo on; set wins over read-clear
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            autoRefused <= 1'b0;
        end else if (autoReq && servoOn) begin
            autoRefused <= 1'b1;
        end else if (busReq.rd && busReq.addr == trsl_pkg::REG_STATUS) begin
            autoRefused <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // manual offset display
    // ------------------------------------------------------------
    // manual adjust needs servo on
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            holdCnt <= 32'h0000_0000;
            offsetShow <= 1'b0;
        end else if (!ctrlReg[trsl_pkg::CTRL_MANUAL_BIT] || !servoOn) begin
            holdCnt <= 32'h0000_0000;
            offsetShow <= 1'b0;
        end else if (!offsetShow) begin
            if (!keys.modeHeld) begin
                holdCnt <= 32'h0000_0000;
            end else if (holdCnt == 32'(HOLD_CYC - 1)) begin
                offsetShow <= 1'b1;
            end else begin
                holdCnt <= holdCnt + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            offsetDisplay <= 12'sh000;
        end else begin
            offsetDisplay <= offsetShow ? offsetReg : 12'sh000;
        end
    end

    // ------------------------------------------------------------
    // analog torque path and lag filter
    // ------------------------------------------------------------
    logic signed [31:0] gain32;
    logic signed [31:0] pctAnalog;
    logic signed [31:0] filtErr;
    assign gain32 = 32'(gainReg);
    assign pctAnalog = (32'(torqueRefAdc) - 32'(offsetReg)) / gain32;
    assign filtErr = (pctAnalog <<< trsl_pkg::FRAC) - filtAcc;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            tickCnt <= 16'h0000;
            filtTick <= 1'b0;
        end else if (tickCnt == 16'(trsl_pkg::FILT_STEP_CYC - 1)) begin
            tickCnt <= 16'h0000;
            filtTick <= 1'b1;
        end else begin
            tickCnt <= tickCnt + 16'h0001;
            filtTick <= 1'b0;
        end
    end

    // y += (x - y) / (tc + 1) each 0.01 ms
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            filtAcc <= 32'sh0000_0000;
        end else if (filtTick) begin
            filtAcc <= filtAcc + filtErr / (32'(filtTcReg) + 32'sh0000_0001);
        end
    end

    // ------------------------------------------------------------
    // reference select and speed limit
    // ------------------------------------------------------------
    logic [15:0] pins16;
    logic [1:0] tSel;
    logic [1:0] cSel;
    logic torqueMode;
    logic presetMode;
    logic signed [15:0] refSel;
    logic signed [31:0] analogRpm;
    logic signed [31:0] baseLim;
    logic signed [31:0] limNext;
    logic overLimit;
    assign pins16 = 16'(digIn);
    assign tSel = {pickPin(pins16, allocAReg[7:4]), pickPin(pins16, allocAReg[3:0])};
    assign cSel = {pickPin(pins16, allocBReg[7:4]), pickPin(pins16, allocBReg[3:0])};
    assign torqueMode = ctrlReg[3:0] == trsl_pkg::MODE_TORQUE;
    assign presetMode = torqueMode && ctrlReg[trsl_pkg::CTRL_TSRC_BIT];
    // analog path when source is 0
    assign refSel = !torqueMode ? 16'sh0000 :
                    presetMode ? tPreReg[tSel] : filtAcc[23:8];
    assign analogRpm = (absS(32'(speedRefAdc)) * MOTOR_RATED_RPM) / (gain32 * 100);

    always_comb begin
        // preset mode limits by the selected cap
        if (presetMode) begin
            baseLim = absS(32'(sCapReg[cSel]));
        end else if (ctrlReg[trsl_pkg::CTRL_SLSRC_BIT]) begin
            baseLim = (analogRpm < 32'(spdLimReg)) ? analogRpm : 32'(spdLimReg);
        end else begin
            baseLim = 32'(spdLimReg);
        end
        limNext = (baseLim > MOTOR_MAX_RPM) ? 32'(MOTOR_MAX_RPM) : baseLim;
    end

    // cut torque pushing past the limit
    assign overLimit = torqueMode && (absS(32'(motorSpeed)) >= limNext) && (refSel != 0)
                       && ((refSel < 0) == (motorSpeed < 0));

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            torqueCmd <= 16'sh0000;
            speedLimit <= 16'h0000;
            limitActive <= 1'b0;
        end else begin
            torqueCmd <= overLimit ? 16'sh0000 : refSel;
            speedLimit <= limNext[15:0];
            limitActive <= overLimit;
        end
    end

    // ------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------
    logic [15:0] rdMux;
    always_comb begin
        case (busReq.addr)
            trsl_pkg::REG_CTRL: rdMux = ctrlReg;
            trsl_pkg::REG_FILT: rdMux = filtTcReg;
            trsl_pkg::REG_SPDLIM: rdMux = spdLimReg;
            trsl_pkg::REG_GAIN: rdMux = gainReg;
            trsl_pkg::REG_ALLOC_A: rdMux = allocAReg;
            trsl_pkg::REG_ALLOC_B: rdMux = allocBReg;
            trsl_pkg::REG_OFFSET: rdMux = 16'(offsetReg);
            trsl_pkg::REG_STATUS: rdMux = {12'h000, torqueMode, autoRefused, limitActive,
                                           offsetShow};
            default: rdMux = busReq.addr[3] ? sCapReg[widx] : tPreReg[widx];
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdData <= 16'h0000;
        end else begin
            rdData <= busReq.rd ? rdMux : 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    a_auto_refused_on: assert property (autoReq && servoOn && !loadPend && !offsetShow
            |=> autoRefused && $stable(offsetReg))
        else $error("auto offset taken while servo on");
    a_auto_capture_val: assert property (autoReq && !servoOn && !loadPend
            |=> offsetReg == $past(adcClamp[11:0]) && nvWriteStb)
        else $error("auto offset not captured");
    a_offset_in_range: assert property (offsetReg <= 12'sh400 && offsetReg >= -12'sh400)
        else $error("offset out of range");
    a_show_after_hold: assert property ($rose(offsetShow)
            |-> $past(holdCnt) == 32'(HOLD_CYC - 1) && $past(keys.modeHeld))
        else $error("offset shown before hold time");
    a_show_needs_servo: assert property (!servoOn |=> !offsetShow)
        else $error("offset shown with servo off");
    a_restore_keeps_offset: assert property (restoreReq && !autoReq && !offsetShow
            && !loadPend |=> $stable(offsetReg) && filtTcReg == trsl_pkg::FILT_DEF)
        else $error("restore disturbed offset");
    a_limit_motor_max: assert property (speedLimit <= 16'(MOTOR_MAX_RPM))
        else $error("speed limit above motor maximum");
    a_preset_passes: assert property (presetMode && !overLimit
            |=> torqueCmd == $past(tPreReg[tSel]))
        else $error("wrong preset on torque output");
    a_limit_cuts_torque: assert property (torqueMode && refSel > 16'sh0000
            && motorSpeed > 16'sh0000 && 32'(motorSpeed) >= limNext
            |=> limitActive && torqueCmd == 16'sh0000)
        else $error("torque not cut at limit");
    a_fixed_limit_src: assert property (torqueMode && !presetMode
            && !ctrlReg[trsl_pkg::CTRL_SLSRC_BIT] && spdLimReg <= 16'(MOTOR_MAX_RPM)
            |=> speedLimit == $past(spdLimReg))
        else $error("fixed limit not applied");

    c_auto_capture: cover property (autoReq && !servoOn ##1 nvWriteStb);
    c_offset_shown: cover property ($rose(offsetShow));
    c_limit_hit: cover property ($rose(limitActive));
endmodule
`default_nettype wire

/* File: hdl/trsl_pkg.sv */
// constants, register map and carrier types of the torque reference select and limit block
package trsl_pkg;
    // ------------------------------------------------------------
    // register map (word index on the register port)
    // ------------------------------------------------------------
    localparam int AW = 4;
    localparam int DW = 16;
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_FILT = 4'h1;
    localparam logic [3:0] REG_SPDLIM = 4'h2;
    localparam logic [3:0] REG_GAIN = 4'h3;
    localparam logic [3:0] REG_TPRE0 = 4'h4;
    localparam logic [3:0] REG_SCAP0 = 4'h8;
    localparam logic [3:0] REG_ALLOC_A = 4'hC;
    localparam logic [3:0] REG_ALLOC_B = 4'hD;
    localparam logic [3:0] REG_OFFSET = 4'hE;
    localparam logic [3:0] REG_STATUS = 4'hF;
    // ------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_TSRC_BIT = 4;
    localparam int CTRL_SLSRC_BIT = 5;
    localparam int CTRL_AUTO_BIT = 6;
    localparam int CTRL_RESTORE_BIT = 7;
    localparam int CTRL_MANUAL_BIT = 8;
    localparam logic [3:0] MODE_TORQUE = 4'h2;
    localparam logic [15:0] CTRL_DEF = 16'h0000;
    localparam logic [15:0] ALLOC_DEF = 16'hFFFF;
    // ------------------------------------------------------------
    // ranges and reset values
    // ------------------------------------------------------------
    localparam logic signed [15:0] FILT_DEF = 16'sh0032;
    localparam logic signed [15:0] FILT_MAX = 16'sh09C4;
    localparam logic signed [15:0] SPDLIM_DEF = 16'sh05DC;
    localparam logic signed [15:0] SPDLIM_MAX = 16'sh1770;
    localparam logic signed [15:0] GAIN_DEF = 16'sh0021;
    localparam logic signed [15:0] GAIN_MIN = 16'sh000A;
    localparam logic signed [15:0] GAIN_MAX = 16'sh0064;
    localparam logic signed [15:0] TPRE_LIM = 16'sh0190;
    localparam logic signed [15:0] TPRE_DEF = 16'sh0000;
    localparam logic signed [15:0] SCAP_LIM = 16'sh1770;
    localparam logic signed [15:0] SCAP_DEF [4] = '{16'sh0064, 16'sh00C8, 16'sh012C, 16'shFF9C};
    localparam logic signed [15:0] OFS_LIM = 16'sh0400;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_NS = 10;
    localparam int FILT_STEP_NS = 10000;
    localparam int FILT_STEP_CYC = FILT_STEP_NS / CLK_NS;
    localparam int KEY_HOLD_MS = 1000;
    localparam int KEY_HOLD_CYC = KEY_HOLD_MS * 1000000 / CLK_NS;
    localparam int FRAC = 8;
    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } trsl_bus_t;
    typedef struct packed {
        logic modeHeld;
        logic up;
        logic down;
    } trsl_keys_t;
endpackage

/* File: tb/trsl_host_model.sv */
// host controller and nonvolatile offset memory model
`timescale 1ns/1ns
`default_nettype none
module trsl_host_model (
    input wire logic ref_clk,
    input wire logic signed [11:0] nvOffsetOut,
    input wire logic nvWriteStb,
    input wire logic signed [15:0] torqueMv,
    input wire logic signed [15:0] speedMv,
    input wire logic [7:0] pins,
    output logic signed [15:0] torqueRefAdc,
    output logic signed [15:0] speedRefAdc,
    output logic [7:0] digIn,
    output logic signed [11:0] nvOffsetIn
);
    logic signed [11:0] nvCell;
    initial nvCell = 12'h000;
    always @(posedge ref_clk) begin
        if (nvWriteStb) begin
            nvCell <= nvOffsetOut;
        end
    end
    assign nvOffsetIn = nvCell;
    assign torqueRefAdc = torqueMv;
    assign speedRefAdc = speedMv;
    assign digIn = pins;
endmodule
`default_nettype wire

/* File: tb/torque_reference_select_limit_tb.sv */
// self-checking bench for the torque reference select and limit block
`timescale 1ns/1ns
`default_nettype none
module torque_reference_select_limit_tb;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic servoOn = 1'b0;
    trsl_pkg::trsl_bus_t bus = '0;
    trsl_pkg::trsl_keys_t keys = '0;
    logic signed [15:0] tMv = 16'h0000, sMv = 16'h0000, motorSpeed = 16'h0000;
    logic [7:0] pins = 8'h00, digIn;
    logic signed [15:0] torqueRefAdc, speedRefAdc, torqueCmd;
    logic [15:0] rdData, speedLimit;
    logic signed [11:0] nvOffsetIn, nvOffsetOut, offsetDisplay;
    logic nvWriteStb, offsetShow, limitActive;
    int failCount = 0, numChecks = 0, i;
    logic [3:0] dIdx [9] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC};
    logic [15:0] dVal [9] = '{16'h0032, 16'h05DC, 16'h0021, 16'h0000, 16'h0064,
        16'h00C8, 16'h012C, 16'hFF9C, 16'hFFFF};
    logic [15:0] pv [4] = '{16'h0064, 16'hFF38, 16'h012C, 16'hFE70};
    logic [15:0] cv [4] = '{16'h0064, 16'h00C8, 16'h012C, 16'h0064};
    always #5 ref_clk = ~ref_clk;
    torque_reference_select_limit #(.MOTOR_MAX_RPM(4000), .HOLD_CYC(20)) u_dut (
        .ref_clk(ref_clk), .reset_n(reset_n), .busReq(bus), .rdData(rdData),
        .servoOn(servoOn), .keys(keys), .digIn(digIn), .torqueRefAdc(torqueRefAdc),
        .speedRefAdc(speedRefAdc), .motorSpeed(motorSpeed), .nvOffsetIn(nvOffsetIn),
        .nvOffsetOut(nvOffsetOut), .nvWriteStb(nvWriteStb), .offsetShow(offsetShow),
        .offsetDisplay(offsetDisplay), .torqueCmd(torqueCmd), .speedLimit(speedLimit),
        .limitActive(limitActive));
    trsl_host_model u_host (.ref_clk(ref_clk), .nvOffsetOut(nvOffsetOut),
        .nvWriteStb(nvWriteStb), .torqueMv(tMv), .speedMv(sMv), .pins(pins),
        .torqueRefAdc(torqueRefAdc), .speedRefAdc(speedRefAdc), .digIn(digIn),
        .nvOffsetIn(nvOffsetIn));
    // ------------------------------------------------------------
    // bus and check tasks
    // ------------------------------------------------------------
    task automatic giveVerdict();
        if (failCount == 0 && numChecks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        numChecks++;
        if (got !== exp) begin
            failCount++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus.rd <= 1'b0;
        #1 chk(rdData, exp);
    endtask
    task automatic settle();
        repeat (3) @(posedge ref_clk);
        #1;
    endtask
    task automatic waitCmd(input logic [15:0] exp);
        for (i = 0; i < 3000 && torqueCmd !== exp; i++) @(posedge ref_clk);
        #1 chk(torqueCmd, exp);
        if (torqueCmd !== exp) giveVerdict();
        @(posedge ref_clk);
    endtask
    task automatic resetDut();
        reset_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        resetDut();
        foreach (dIdx[k]) rd(dIdx[k], dVal[k]);
        wr(4'h2, 16'h1B58);
        rd(4'h2, 16'h1770);
        wr(4'h1, 16'h0BB8);
        rd(4'h1, 16'h09C4);
        wr(4'h0, 16'h0002);
        settle();
        chk(speedLimit, 16'h0FA0);
        wr(4'h2, 16'h05DC);
        settle();
        chk(speedLimit, 16'h05DC);
        wr(4'h0, 16'h0022);
        sMv <= -16'sd1100;
        settle();
        chk(speedLimit, 16'h03E8);
        @(posedge ref_clk);
        sMv <= 16'sd6600;
        settle();
        chk(speedLimit, 16'h05DC);
        for (i = 0; i < 4; i++) wr(4'(4 + i), pv[i]);
        wr(4'hC, 16'h0010);
        wr(4'hD, 16'h0032);
        wr(4'h0, 16'h0012);
        for (int k = 0; k < 4; k++) begin
            @(posedge ref_clk);
            pins <= {4'h0, 2'(k), 2'(k)};
            settle();
            chk(torqueCmd, pv[k]);
            chk(speedLimit, cv[k]);
        end
        @(posedge ref_clk);
        pins <= 8'h00;
        motorSpeed <= 16'sd100;
        settle();
        chk({limitActive, 15'(torqueCmd)}, 16'h8000);
        @(posedge ref_clk);
        motorSpeed <= 16'sd0;
        tMv <= 16'sd37;
        wr(4'h0, 16'h0042);
        #1 chk({nvWriteStb, 3'h0, 12'(nvOffsetOut)}, 16'h8025);
        @(posedge ref_clk);
        servoOn <= 1'b1;
        tMv <= 16'sd500;
        wr(4'h0, 16'h0042);
        settle();
        rd(4'hE, 16'h0025);
        rd(4'hF, 16'h000C);
        wr(4'h3, 16'h0005);
        rd(4'h3, 16'h000A);
        wr(4'h0, 16'h0080);
        rd(4'h1, 16'h0032);
        rd(4'h3, 16'h0021);
        rd(4'hE, 16'h0025);
        @(posedge ref_clk);
        resetDut();
        rd(4'hE, 16'h0025);
        wr(4'h0, 16'h0002);
        wr(4'h1, 16'h0000);
        tMv <= 16'sd3337;
        waitCmd(16'h0064);
        tMv <= -16'sd1613;
        waitCmd(16'hFFCE);
        servoOn <= 1'b0;
        tMv <= 16'sd2000;
        wr(4'h0, 16'h0042);
        servoOn <= 1'b1;
        settle();
        chk(16'(nvOffsetOut), 16'h0400);
        wr(4'h0, 16'h0102);
        keys.modeHeld <= 1'b1;
        repeat (10) @(posedge ref_clk);
        #1 chk(16'(offsetShow), 16'h0000);
        for (i = 0; i < 40 && offsetShow !== 1'b1; i++) @(posedge ref_clk);
        #1 chk(16'(offsetShow), 16'h0001);
        if (offsetShow !== 1'b1) giveVerdict();
        @(posedge ref_clk);
        keys.up <= 1'b1;
        @(posedge ref_clk);
        keys.up <= 1'b0;
        settle();
        chk(16'(nvOffsetOut), 16'h0400);
        @(posedge ref_clk);
        keys.down <= 1'b1;
        @(posedge ref_clk);
        keys.down <= 1'b0;
        settle();
        chk(16'(offsetDisplay), 16'h03FF);
        @(posedge ref_clk);
        servoOn <= 1'b0;
        settle();
        chk(16'(offsetShow), 16'h0000);
        giveVerdict();
    end
endmodule
`default_nettype wire
